// ===== rtl/soft_power_pkg.sv
package soft_power_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SLEEP_WAKE_CFG  = 8'hF0;
  localparam logic [7:0] IDX_GPIO_A          = 8'hF6;
  localparam logic [7:0] IDX_GPIO_E          = 8'hF9;
  localparam logic [7:0] IDX_GPIO_F          = 8'hFA;
  localparam logic [7:0] IDX_DELAY2_SET      = 8'hB8;
  localparam logic [7:0] IDX_SOFT_POWER_CTRL = 8'hF5;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'hE1;
  localparam logic [7:0] IDX_SLEEP_CTRL      = 8'hE2;
  localparam logic [7:0] IDX_GPIO_ROUTE      = 8'hE3;
  localparam logic [7:0] IDX_WATCHDOG_CTRL   = 8'hF4;
  localparam logic [7:0] IDX_NONE            = 8'h00;

  // low aliases seen outside configuration mode
  localparam logic [7:0] ALIAS_GPIO_A        = 8'h01;
  localparam logic [7:0] ALIAS_WATCHDOG      = 8'h02;
  localparam logic [7:0] ALIAS_GPIO_E        = 8'h03;
  localparam logic [7:0] ALIAS_GPIO_F        = 8'h04;
  localparam logic [7:0] ALIAS_SOFT_POWER    = 8'h05;
  localparam logic [7:0] ALIAS_IRQ_STATUS    = 8'h06;

  // field positions
  localparam int SPC_RSVD_BIT   = 4;
  localparam int SPC_HALT_BIT   = 5;
  localparam int SPC_REARM_BIT  = 6;
  localparam int SPC_FORCE_BIT  = 7;
  localparam int CFG_SLEEP_SEL  = 0;
  localparam int CFG_WAKE_SEL   = 1;
  localparam int SC_SLEEP_EN    = 0;
  localparam int SC_TYPE_LSB    = 1;
  localparam int RT_GROUP_A     = 0;
  localparam int RT_GROUP_E     = 1;
  localparam int RT_GROUP_F     = 2;
  localparam int IST_WAKE       = 0;
  localparam int IST_SLEEP_SMI  = 1;
  localparam int IST_PDOWN      = 2;
  localparam int IRQ_BITS       = 3;

  // values after reset
  localparam logic [7:0] SLEEP_WAKE_CFG_RST = 8'h00;
  localparam logic [7:0] DELAY2_SET_RST     = 8'h05;
  localparam logic [7:0] BYTE_ZERO          = 8'h00;

  // delay 2 is counted in units of this many milliseconds
  localparam int DELAY2_UNIT_MS     = 100;
  localparam int CLK_HZ             = 40_000_000;
  localparam int DELAY2_UNIT_CYCLES = DELAY2_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    CD_IDLE = 3'b001,
    CD_RUN  = 3'b010,
    CD_HALT = 3'b100
  } countdown_state_type;

endpackage

// ===== rtl/soft_power_regs.sv
// How it works
// - writing one to halt bit stops delay 2 without power down; self clears
// - halt bit reads zero while counting, one once stopped
// - writing one to rearm bit restarts delay 2 from zero while running or halted; self clears, repeatable
// - writing one to forced poweroff bit requests power down at once; self clears
// - delay 2 length comes from time-set register at index B8, default 500 ms
// - group a readback shows its eight pins, pin n in bit n
// - group e readback shows five pins in bits 0..4, bits 7..5 reserved
// - group f readback shows all eight pins, pin n in bit n
// - outside configuration mode readbacks and controls also decode at indices 01..06
// - group a routes to first combined irq, groups e and f to second
// - sleep select zero: sleep enable write starts sleep; sleep_type shows the type it writes one cycle after sleep_start
// - sleep select one: sleep enable write raises smi, no sleep
// - every sleep enable write sets the smi flag; smi only if select enables
// - wake select zero: wake status set only on power-on request falling edge
// - wake select one: wake status set on enabled wake event or that edge
`timescale 1ns/1ps
module soft_power_regs
  import soft_power_pkg::*;
#(
  parameter int UNIT_CYCLES = DELAY2_UNIT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        config_mode,
  input  wire logic        power_button,
  input  wire logic        power_on_request_n,
  input  wire logic        wake_event,
  input  wire logic [7:0]  gpio_group_a_pins,
  input  wire logic [4:0]  gpio_group_e_pins,
  input  wire logic [7:0]  gpio_group_f_pins,
  output logic             power_down_req,
  output logic             sleep_start,
  output logic [2:0]       sleep_type,
  output logic             smi,
  output logic             irq,
  output logic             combined_gpio_irq_first,
  output logic             combined_gpio_irq_second
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  // canonical index for a bus index, IDX_NONE when unmapped
  function automatic logic [7:0] map_index(input logic [7:0] idx, input logic cfg);
    logic [7:0] m;
    m = IDX_NONE;
    if (!cfg) begin
      case (idx)
        ALIAS_GPIO_A:     m = IDX_GPIO_A;
        ALIAS_WATCHDOG:   m = IDX_WATCHDOG_CTRL;
        ALIAS_GPIO_E:     m = IDX_GPIO_E;
        ALIAS_GPIO_F:     m = IDX_GPIO_F;
        ALIAS_SOFT_POWER: m = IDX_SOFT_POWER_CTRL;
        ALIAS_IRQ_STATUS: m = IDX_IRQ_STATUS;
        default:          m = IDX_NONE;
      endcase
    end
    case (idx)
      IDX_SLEEP_WAKE_CFG, IDX_GPIO_A, IDX_GPIO_E, IDX_GPIO_F, IDX_DELAY2_SET,
      IDX_SOFT_POWER_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_SLEEP_CTRL,
      IDX_GPIO_ROUTE, IDX_WATCHDOG_CTRL: m = idx;
      default: ;
    endcase
    return m;
  endfunction

  logic [7:0] bus_idx;
  logic [7:0] reg_idx;
  logic       addr_ok;
  logic       access;
  logic       wr;
  logic [7:0] wbyte;

  // word aligned, only the low 256 words exist
  assign bus_idx = paddr[9:2];
  assign reg_idx = map_index(bus_idx, config_mode);
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && (reg_idx != IDX_NONE);
  assign access  = psel && penable && pready;
  assign wr      = access && pwrite && addr_ok;
  assign wbyte   = pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0]          sleep_wake_cfg_r;
  logic [7:0]          delay2_set_r;
  logic [2:0]          sleep_type_r;
  logic [2:0]          route_r;
  logic [IRQ_BITS-1:0] irq_status_r;
  logic [IRQ_BITS-1:0] irq_mask_r;
  countdown_state_type cd_state_r;
  countdown_state_type cd_state_nxt;
  logic [31:0]         unit_cnt_r;
  logic [7:0]          units_r;
  logic                button_d_r;
  logic                pon_d_r;

  // write strobes for the self clearing controls
  logic halt_wr;
  logic rearm_wr;
  logic force_wr;
  logic sleep_en_wr;
  logic button_rise;
  logic pon_fall;
  logic cd_done;
  logic restart;
  logic pdown_evt;

  assign halt_wr     = wr && (reg_idx == IDX_SOFT_POWER_CTRL) && wbyte[SPC_HALT_BIT];
  assign rearm_wr    = wr && (reg_idx == IDX_SOFT_POWER_CTRL) && wbyte[SPC_REARM_BIT];
  assign force_wr    = wr && (reg_idx == IDX_SOFT_POWER_CTRL) && wbyte[SPC_FORCE_BIT];
  assign sleep_en_wr = wr && (reg_idx == IDX_SLEEP_CTRL) && wbyte[SC_SLEEP_EN];
  assign button_rise = power_button && !button_d_r;
  assign pon_fall    = pon_d_r && !power_on_request_n;

  // configuration registers; reserved cfg bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_wake_cfg_r <= SLEEP_WAKE_CFG_RST;
      delay2_set_r     <= DELAY2_SET_RST;
      sleep_type_r     <= 3'h0;
      route_r          <= 3'h0;
      irq_mask_r       <= '0;
    end else if (wr) begin
      if (reg_idx == IDX_SLEEP_WAKE_CFG) sleep_wake_cfg_r <= {6'h00, wbyte[1:0]};
      if (reg_idx == IDX_DELAY2_SET)     delay2_set_r <= wbyte;
      if (reg_idx == IDX_SLEEP_CTRL)     sleep_type_r <= wbyte[SC_TYPE_LSB +: 3];
      if (reg_idx == IDX_GPIO_ROUTE)     route_r <= wbyte[2:0];
      if (reg_idx == IDX_IRQ_MASK)       irq_mask_r <= wbyte[IRQ_BITS-1:0];
    end
  end

  // edge detect registers for button and power-on request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      button_d_r <= 1'b0;
      pon_d_r    <= 1'b1;
    end else begin
      button_d_r <= power_button;
      pon_d_r    <= power_on_request_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay 2 countdown

  // done once the programmed number of units has elapsed
  assign cd_done = (cd_state_r == CD_RUN) && (units_r >= delay2_set_r);
  // rearm while halted or running starts over; a new press does too unless running
  assign restart = rearm_wr || (button_rise && (cd_state_r != CD_RUN));

  always_comb begin
    cd_state_nxt = cd_state_r;
    case (cd_state_r)
      CD_IDLE: if (button_rise) cd_state_nxt = CD_RUN;
      CD_RUN: begin
        if (halt_wr) cd_state_nxt = CD_HALT;
        else if (rearm_wr) cd_state_nxt = CD_RUN;
        else if (cd_done) cd_state_nxt = CD_IDLE;
      end
      CD_HALT: if (restart && !halt_wr) cd_state_nxt = CD_RUN;
      default: cd_state_nxt = CD_IDLE;
    endcase
    if (force_wr) cd_state_nxt = CD_IDLE;
  end

  // halt or rearm landing on the last count still keeps the system up
  assign pdown_evt = force_wr || (cd_done && !halt_wr && !rearm_wr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cd_state_r <= CD_IDLE;
    else          cd_state_r <= cd_state_nxt;
  end

  // unit prescaler; the long count is a parameter so benches can shrink it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_r <= 32'h0;
      units_r    <= 8'h00;
    end else if (restart || cd_state_r != CD_RUN) begin
      unit_cnt_r <= 32'h0;
      units_r    <= 8'h00;
    end else if (unit_cnt_r == 32'(UNIT_CYCLES - 1)) begin
      unit_cnt_r <= 32'h0;
      units_r    <= (units_r == 8'hFF) ? units_r : units_r + 8'h01;
    end else begin
      unit_cnt_r <= unit_cnt_r + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky event status, write one to clear, set wins

  logic [IRQ_BITS-1:0] evt_set;
  logic [IRQ_BITS-1:0] evt_clr;
  logic                wake_hit;

  assign wake_hit = sleep_wake_cfg_r[CFG_WAKE_SEL] ? (pon_fall || wake_event)
                                                   : pon_fall;
  assign evt_set[IST_WAKE]      = wake_hit;
  assign evt_set[IST_SLEEP_SMI] = sleep_en_wr;
  assign evt_set[IST_PDOWN]     = pdown_evt;
  assign evt_clr = (wr && reg_idx == IDX_IRQ_STATUS) ? wbyte[IRQ_BITS-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_BITS; gi++) begin : g_sticky
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)         irq_status_r[gi] <= 1'b0;
        else if (evt_set[gi]) irq_status_r[gi] <= 1'b1;
        else if (evt_clr[gi]) irq_status_r[gi] <= 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic [7:0] rd_byte;
  logic       halted;

  assign halted = (cd_state_r != CD_RUN);

  // read mux; rearm, force, sleep enable and reserved bits read zero; halt bit reads the countdown state
  always_comb begin
    rd_byte = BYTE_ZERO;
    case (reg_idx)
      IDX_SLEEP_WAKE_CFG:  rd_byte = sleep_wake_cfg_r;
      IDX_GPIO_A:          rd_byte = gpio_group_a_pins;
      IDX_GPIO_E:          rd_byte = {3'b000, gpio_group_e_pins};
      IDX_GPIO_F:          rd_byte = gpio_group_f_pins;
      IDX_DELAY2_SET:      rd_byte = delay2_set_r;
      IDX_SOFT_POWER_CTRL: rd_byte = {2'b00, halted, 5'h00};
      IDX_IRQ_STATUS:      rd_byte = {5'h00, irq_status_r};
      IDX_IRQ_MASK:        rd_byte = {5'h00, irq_mask_r};
      IDX_SLEEP_CTRL:      rd_byte = {4'h0, sleep_type_r, 1'b0};
      IDX_GPIO_ROUTE:      rd_byte = {5'h00, route_r};
      default:             rd_byte = BYTE_ZERO;
    endcase
  end

  // no wait states: data is latched in setup so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= {24'h000000, rd_byte};
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // system side requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_req           <= 1'b0;
      sleep_start              <= 1'b0;
      sleep_type               <= 3'h0;
      smi                      <= 1'b0;
      irq                      <= 1'b0;
      combined_gpio_irq_first  <= 1'b0;
      combined_gpio_irq_second <= 1'b0;
    end else begin
      power_down_req <= pdown_evt;
      sleep_start    <= sleep_en_wr && !sleep_wake_cfg_r[CFG_SLEEP_SEL];
      sleep_type     <= sleep_type_r;
      smi            <= irq_status_r[IST_SLEEP_SMI] && sleep_wake_cfg_r[CFG_SLEEP_SEL];
      irq            <= |(irq_status_r & irq_mask_r);
      combined_gpio_irq_first  <= route_r[RT_GROUP_A] && |gpio_group_a_pins;
      combined_gpio_irq_second <= (route_r[RT_GROUP_E] && |gpio_group_e_pins) ||
                                  (route_r[RT_GROUP_F] && |gpio_group_f_pins);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HALT_NO_PDOWN: assert property (
    (cd_state_r == CD_RUN && halt_wr && !force_wr) |=> !power_down_req && cd_state_r == CD_HALT)
    else $error("halt did not stop countdown cleanly");

  AST_HALT_READ: assert property (
    (psel && !penable && reg_idx == IDX_SOFT_POWER_CTRL) |=>
      prdata[SPC_HALT_BIT] == (cd_state_r != CD_RUN) || $changed(cd_state_r))
    else $error("halt bit read disagrees with countdown");

  AST_REARM_RESTART: assert property (
    (rearm_wr && !halt_wr && !force_wr && cd_state_r != CD_IDLE) |=> cd_state_r == CD_RUN
      && units_r == 8'h00
      && unit_cnt_r == 32'h0)
    else $error("rearm did not restart countdown");

  AST_FORCE_PDOWN: assert property (
    force_wr |=> power_down_req && cd_state_r == CD_IDLE)
    else $error("forced poweroff missed");

  AST_PDOWN_CAUSE: assert property (
    power_down_req |-> $past(force_wr) || ($past(cd_state_r) == CD_RUN
      && $past(units_r) >= $past(delay2_set_r)))
    else $error("power down without cause");

  AST_GPIO_E_RSVD: assert property (
    (psel && !penable && reg_idx == IDX_GPIO_E) |=> prdata[7:5] == 3'b000)
    else $error("group e reserved bits not zero");

  AST_SLEEP_SEQ: assert property (
    (sleep_en_wr && !sleep_wake_cfg_r[CFG_SLEEP_SEL]) |=> sleep_start)
    else $error("sleep not started");

  AST_SLEEP_SMI: assert property (
    (sleep_en_wr && sleep_wake_cfg_r[CFG_SLEEP_SEL] && !$fell(sleep_wake_cfg_r[0]))
      |=> !sleep_start ##1 smi)
    else $error("sleep select one did not raise smi");

  AST_SMI_FLAG: assert property (
    sleep_en_wr |=> irq_status_r[IST_SLEEP_SMI])
    else $error("sleep smi flag not set");

  AST_WAKE_ONLY_EDGE: assert property (
    (!sleep_wake_cfg_r[CFG_WAKE_SEL] && !irq_status_r[IST_WAKE] && !pon_fall)
      |=> !irq_status_r[IST_WAKE])
    else $error("wake status set without edge");

  AST_WAKE_EVENT: assert property (
    (sleep_wake_cfg_r[CFG_WAKE_SEL] && wake_event) |=> irq_status_r[IST_WAKE])
    else $error("wake event lost");

  AST_CFG_RSVD: assert property (
    sleep_wake_cfg_r[7:2] == 6'h00)
    else $error("reserved cfg bits set");

  // corner cases of the countdown and the bus timing
  // a rearm on the very last count must not let the timeout through
  AST_REARM_BEATS_DONE: assert property (
    (cd_done && rearm_wr && !halt_wr && !force_wr) |=> !power_down_req && cd_state_r == CD_RUN)
    else $error("rearm lost to a timeout in the same cycle");

  AST_SPC_SELF_CLEAR: assert property (
    (psel && !penable && reg_idx == IDX_SOFT_POWER_CTRL) |=>
      prdata[7:6] == 2'b00 && prdata[4:0] == 5'h00)
    else $error("self clearing control bits read back set");

  AST_WAKE_EDGE: assert property (
    pon_fall |=> irq_status_r[IST_WAKE])
    else $error("power-on request edge did not set wake status");

  AST_STATUS_W1C: assert property (
    (evt_clr[IST_PDOWN] && !evt_set[IST_PDOWN]) |=> !irq_status_r[IST_PDOWN])
    else $error("power down status not cleared by write of one");

  AST_PREADY_ONE: assert property (
    (psel && !penable) |=> pready)
    else $error("no access cycle after setup");

  COV_PDOWN_TIMEOUT: cover property (cd_done ##1 power_down_req);
  COV_HALT_THEN_REARM: cover property (halt_wr ##[1:100] rearm_wr);
  COV_REARM_WHILE_RUN: cover property (rearm_wr && cd_state_r == CD_RUN);
  COV_SLEEP_SMI: cover property (sleep_en_wr && sleep_wake_cfg_r[CFG_SLEEP_SEL]);
  COV_ALIAS_READ: cover property (access && !config_mode && bus_idx == ALIAS_GPIO_A);

endmodule // soft_power_regs

// ===== testbench/tb_soft_power_regs.sv
`timescale 1ns/1ps
module tb_soft_power_regs
  import soft_power_pkg::*;
;
  localparam int UC = 4;
  ////////////////////////////////////////////////////////////////////////////////
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        config_mode = 1'b1;
  logic        power_button = 1'b0;
  logic        pon_n = 1'b1;
  logic        wake_event = 1'b0;
  logic [7:0]  gpa = 8'h00;
  logic [4:0]  gpe = 5'h00;
  logic [7:0]  gpf = 8'h00;
  logic        power_down_req;
  logic        sleep_start;
  logic [2:0]  sleep_type;
  logic        smi;
  logic        irq;
  logic        gi_first;
  logic        gi_second;
  logic [31:0] rdv;
  logic        errv;
  int          n_fail = 0;
  int          check_count = 0;
  int          pd_cnt = 0;
  int          ss_cnt = 0;
  int          n;
  int          p;

  soft_power_regs #(.UNIT_CYCLES(UC)) soft_power_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_mode(config_mode), .power_button(power_button), .power_on_request_n(pon_n),
    .wake_event(wake_event), .gpio_group_a_pins(gpa), .gpio_group_e_pins(gpe),
    .gpio_group_f_pins(gpf), .power_down_req(power_down_req), .sleep_start(sleep_start),
    .sleep_type(sleep_type), .smi(smi), .irq(irq), .combined_gpio_irq_first(gi_first),
    .combined_gpio_irq_second(gi_second)
  );

  // clock, 25 ns period
  always #12.5 pclk = ~pclk;

  // one-cycle pulses are counted on the falling edge, where they are settled
  always @(negedge pclk) begin
    if (power_down_req === 1'b1) pd_cnt++;
    if (sleep_start === 1'b1) ss_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; pready is sampled at the rising edge, where the write lands
  // and read data is taken; only after that edge is the request released
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 20) begin
      @(posedge pclk);
      w++;
    end
    chk(33'(pready === 1'b1), 33'h1);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [32:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({errv, rdv}, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic press();
    @(posedge pclk) power_button <= 1'b1;
    @(posedge pclk) power_button <= 1'b0;
  endtask

  // falling edges until the next power-down pulse, bounded by lim
  task automatic wait_pd(input int lim, output int k);
    int s;
    s = pd_cnt;
    k = 0;
    while (pd_cnt == s && k < lim) begin
      @(negedge pclk);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(IDX_SLEEP_WAKE_CFG, 33'h0);
    rdchk(IDX_DELAY2_SET, 33'h05);
    rdchk(IDX_SOFT_POWER_CTRL, 33'h20);
    wr(IDX_SLEEP_WAKE_CFG, 8'hFC);
    rdchk(IDX_SLEEP_WAKE_CFG, 33'h0);
    rdchk(8'h10, 33'h100000000);
  endtask

  task automatic t_gpio();
    @(posedge pclk);
    gpa <= 8'hA5;
    gpe <= 5'h1B;
    gpf <= 8'h3C;
    cyc(2);
    rdchk(IDX_GPIO_A, 33'hA5);
    rdchk(IDX_GPIO_E, 33'h1B);
    rdchk(IDX_GPIO_F, 33'h3C);
    // low aliases only exist while out of configuration mode
    @(posedge pclk) config_mode <= 1'b0;
    rdchk(ALIAS_GPIO_A, 33'hA5);
    rdchk(ALIAS_GPIO_E, 33'h1B);
    rdchk(ALIAS_GPIO_F, 33'h3C);
    rdchk(ALIAS_SOFT_POWER, 33'h20);
    rdchk(8'h07, 33'h100000000);
    @(posedge pclk) config_mode <= 1'b1;
  endtask

  task automatic t_countdown();
    wr(IDX_DELAY2_SET, 8'h03);
    press();
    wait_pd(60, n);
    chk(33'(n >= 3 * UC - 1 && n <= 3 * UC + 5), 33'h1);
    press();
    rdchk(IDX_SOFT_POWER_CTRL, 33'h00);
    wr(IDX_SOFT_POWER_CTRL, 8'h20);
    p = pd_cnt;
    cyc(30);
    chk(33'(pd_cnt == p), 33'h1);
    rdchk(IDX_SOFT_POWER_CTRL, 33'h20);
    press();
    cyc(6);
    wr(IDX_SOFT_POWER_CTRL, 8'h40);
    wait_pd(60, n);
    chk(33'(n >= 3 * UC - 3 && n <= 3 * UC + 5), 33'h1);
    wr(IDX_SOFT_POWER_CTRL, 8'h80);
    wait_pd(6, n);
    chk(33'(n < 4), 33'h1);
    rdchk(IDX_SOFT_POWER_CTRL, 33'h20);
  endtask

  task automatic t_irq();
    rdchk(IDX_IRQ_STATUS, 33'h04);
    cyc(2);
    chk(33'(irq), 33'h0);
    wr(IDX_IRQ_MASK, 8'h04);
    cyc(2);
    chk(33'(irq), 33'h1);
    wr(IDX_IRQ_STATUS, 8'h04);
    cyc(2);
    chk(33'(irq), 33'h0);
    rdchk(IDX_IRQ_STATUS, 33'h00);
  endtask

  task automatic t_sleep();
    wr(IDX_SLEEP_WAKE_CFG, 8'h00);
    p = ss_cnt;
    wr(IDX_SLEEP_CTRL, 8'h07);
    cyc(3);
    chk(33'(ss_cnt == p + 1), 33'h1);
    chk(33'(sleep_type), 33'h3);
    chk(33'(smi), 33'h0);
    rdchk(IDX_IRQ_STATUS, 33'h02);
    wr(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_SLEEP_WAKE_CFG, 8'h01);
    p = ss_cnt;
    wr(IDX_SLEEP_CTRL, 8'h01);
    cyc(3);
    chk(33'(ss_cnt == p), 33'h1);
    chk(33'(smi), 33'h1);
    rdchk(IDX_IRQ_STATUS, 33'h02);
    wr(IDX_IRQ_STATUS, 8'h02);
    cyc(3);
    chk(33'(smi), 33'h0);
  endtask

  task automatic t_wake();
    wr(IDX_SLEEP_WAKE_CFG, 8'h00);
    @(posedge pclk) wake_event <= 1'b1;
    @(posedge pclk) wake_event <= 1'b0;
    cyc(3);
    rdchk(IDX_IRQ_STATUS, 33'h00);
    @(posedge pclk) pon_n <= 1'b0;
    cyc(3);
    rdchk(IDX_IRQ_STATUS, 33'h01);
    @(posedge pclk) pon_n <= 1'b1;
    wr(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_SLEEP_WAKE_CFG, 8'h02);
    @(posedge pclk) wake_event <= 1'b1;
    @(posedge pclk) wake_event <= 1'b0;
    cyc(3);
    rdchk(IDX_IRQ_STATUS, 33'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    @(posedge pclk) pon_n <= 1'b0;
    cyc(3);
    rdchk(IDX_IRQ_STATUS, 33'h01);
    @(posedge pclk) pon_n <= 1'b1;
  endtask

  task automatic t_route();
    wr(IDX_GPIO_ROUTE, 8'h01);
    cyc(2);
    chk(33'({gi_first, gi_second}), 33'h2);
    wr(IDX_GPIO_ROUTE, 8'h02);
    cyc(2);
    chk(33'({gi_first, gi_second}), 33'h1);
    @(posedge pclk) gpe <= 5'h00;
    cyc(2);
    chk(33'({gi_first, gi_second}), 33'h0);
    wr(IDX_GPIO_ROUTE, 8'h04);
    cyc(2);
    chk(33'({gi_first, gi_second}), 33'h1);
    @(posedge pclk) gpf <= 8'h00;
    cyc(2);
    chk(33'({gi_first, gi_second}), 33'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gpio();
    t_countdown();
    t_irq();
    t_sleep();
    t_wake();
    t_route();
    end_sim();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #500000;
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // tb_soft_power_regs
